// ### inc/axm_defines.vh
`ifndef AXM_DEFINES_VH
`define AXM_DEFINES_VH
// Bus decode: global word, then one 8-word window per axis
`define AXM_AXES 4
`define AXM_ADDR_HALT 8'h00
`define AXM_AXIS_BASE_IDX 3'h1
// Word index inside an axis window
`define AXM_OFS_CTRL 3'h0
`define AXM_OFS_STEP 3'h1
`define AXM_OFS_CFG 3'h2
`define AXM_OFS_STAT 3'h3
`define AXM_OFS_POS 3'h4
`define AXM_OFS_ICAP 3'h5
`define AXM_OFS_DCMD 3'h6
`define AXM_OFS_DLIM 3'h7
// Control field positions
`define AXM_CTL_MODE 0
`define AXM_CTL_STEP_INV 1
`define AXM_CTL_DIR_INV 2
`define AXM_CTL_INH_HIGH 3
`define AXM_CTL_INH_SW 4
`define AXM_CTL_AUTO_INH 5
`define AXM_CTL_ENA_LSB 8
`define AXM_CTL_INV_LSB 12
`define AXM_CTL_ARM 16
`define AXM_CTL_EFILT_LSB 20
`define AXM_CTL_WIDTH 24
// Status field positions
`define AXM_ST_KILLED 8
`define AXM_ST_LIMSTOP 9
`define AXM_ST_ICAP 10
`define AXM_ST_REFUSED 11
// Reset values
`define AXM_CTRL_RST 24'h00_0000
`define AXM_PERIOD_RST 16'h0019
`define AXM_DLIM_RST 32'h7FFF_8000
// Timing: limit and home filter time and clock rate
`define AXM_LIM_FILT_US 1000
`define AXM_CLK_MHZ 50
`define AXM_LIM_FILT_CYC (`AXM_LIM_FILT_US * `AXM_CLK_MHZ)
`endif

// ### hdl/axm_motion_io.v
// Summary of operation
// - Step mode: pulse per step, direction level
// - Pulse mode: forward or reverse pin pulses
// - Both stepper outputs have programmable polarity
// - Inhibit polarity programmable, active-low default
// - Halt-all or kill error asserts inhibit
// - Software drives inhibit directly
// - Limit and home inputs individually enabled
// - Enabled active transition halts the axis
// - Active limit refuses motion that way
// - Limit inputs filtered, 1 ms minimum
// - Released limit no longer blocks moves
// - Limit and home polarity programmable
// - Input states always readable
// - Quadrature to signed 32-bit count
// - Leading phase sets direction, every edge
// - Four counts per encoder line
// - Counts at up to 20 MHz
// - Armed index edge captures position
// - Encoders count regardless of axis use
// - Analog command clamped plus offset
// - Encoder inputs have programmable filter
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "axm_defines.vh"
module axm_motion_io #(
   parameter LIM_FILT_CYC = `AXM_LIM_FILT_CYC
) (
   input wire pclk, // Bus and logic clock
   input wire presetn, // Async reset, active low
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB direction
   input wire [7:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output wire [31:0] prdata, // APB read data
   output wire pready, // APB ready
   output wire pslverr, // APB error, unmapped
   input wire [3:0] fwd_limit_in, // Forward limit pins
   input wire [3:0] rev_limit_in, // Reverse limit pins
   input wire [3:0] home_in, // Home pins
   input wire [3:0] enc_a_in, // Encoder phase A
   input wire [3:0] enc_b_in, // Encoder phase B
   input wire [3:0] enc_index_in, // Encoder index
   input wire [3:0] kill_err, // Kill error per axis
   input wire [3:0] step_or_forward_pulse_in, // Pin readback
   output wire [3:0] step_or_forward_pulse_out, // Always low
   output wire [3:0] step_or_forward_pulse_oe_n, // Low pulls pin low
   input wire [3:0] direction_or_reverse_pulse_in, // Pin readback
   output wire [3:0] direction_or_reverse_pulse_out, // Always low
   output wire [3:0] direction_or_reverse_pulse_oe_n, // Low pulls pin low
   input wire [3:0] inhibit_in, // Pin readback
   output wire [3:0] inhibit_out, // Always low
   output wire [3:0] inhibit_oe_n, // Low pulls pin low
   output wire [63:0] dac_value // Four 16-bit commands
);
   // Quadrature step: 01 up, 11 down, 00 none; pairs are {a,b}
   function [1:0] axm_quad;
      input [3:0] pc;
      begin
         case (pc)
            4'h2, 4'hB, 4'hD, 4'h4: axm_quad = 2'h1;
            4'h8, 4'hE, 4'h7, 4'h1: axm_quad = 2'h3;
            default: axm_quad = 2'h0;
         endcase
      end
   endfunction

   wire setup = psel & ~penable;
   wire wr = psel & penable & pwrite;
   wire halt_all = wr & (paddr == `AXM_ADDR_HALT) & pwdata[0];
   wire [2:0] win = paddr[7:5] - `AXM_AXIS_BASE_IDX;
   wire axis_hit = (paddr[7:5] != 3'h0) && (paddr[7:5] <= 3'h4) && (paddr[1:0] == 2'h0);
   wire glob_hit = (paddr == `AXM_ADDR_HALT);
   wire [127:0] rd_flat;
   reg [31:0] prdata_reg;
   reg pslverr_reg;

   // Registered answer: data sampled in setup, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= axis_hit ? rd_flat[win[1:0]*32 +: 32] : 32'h0000_0000;
         pslverr_reg <= ~(axis_hit | glob_hit);
      end
   end
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready = 1'b1;

   wire [23:0] raw = {enc_index_in, enc_b_in, enc_a_in, home_in, rev_limit_in, fwd_limit_in};
   reg [23:0] sy1_reg, sy2_reg, sy3_reg, sett_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_reg <= 24'h00_0000;
         sy2_reg <= 24'h00_0000;
         sy3_reg <= 24'h00_0000;
         sett_reg <= 24'h00_0000;
      end else begin
         sy1_reg <= raw;
         sy2_reg <= sy1_reg;
         sy3_reg <= sy2_reg;
         // Change counts only once second and third stages agree
         sett_reg <= (~(sy2_reg ^ sy3_reg) & sy3_reg) | ((sy2_reg ^ sy3_reg) & sett_reg);
      end
   end

   assign step_or_forward_pulse_out = 4'h0;
   assign direction_or_reverse_pulse_out = 4'h0;
   assign inhibit_out = 4'h0;

   genvar i, j;
   generate
      for (i = 0; i < `AXM_AXES; i = i + 1) begin : g_axis
         wire sel = wr & axis_hit & (win[1:0] == i);
         wire [2:0] ofs = paddr[4:2];
         reg [`AXM_CTL_WIDTH-1:0] ctrl_reg;
         reg [31:0] cfg_reg, dlim_reg, dcmd_reg;
         reg arm_reg;
         reg killed_reg, limstop_reg, icap_reg, refused_reg;
         wire [2:0] ena = ctrl_reg[`AXM_CTL_ENA_LSB +: 3];
         wire [2:0] inv = ctrl_reg[`AXM_CTL_INV_LSB +: 3];
         wire [2:0] lvl = {sett_reg[8+i], sett_reg[4+i], sett_reg[i]} ^ inv;
         wire [2:0] act;
         reg [2:0] act_d_reg;

         for (j = 0; j < 3; j = j + 1) begin : g_lim
            reg [16:0] cnt_reg;
            always @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  cnt_reg <= 17'h0_0000;
               end else if (!lvl[j]) begin
                  cnt_reg <= 17'h0_0000;
               end else if (cnt_reg < LIM_FILT_CYC) begin
                  cnt_reg <= cnt_reg + 17'h0_0001;
               end
            end
            assign act[j] = (cnt_reg >= LIM_FILT_CYC);
         end

         // only enabled inputs act on motion
         wire [2:0] act_en = act & ena;
         // enabled active edge trips a halt
         wire lim_trip = |(act_en & ~act_d_reg);
         wire halt = halt_all | kill_err[i] | lim_trip;

         wire [2:0] eraw = {sett_reg[20+i], sett_reg[16+i], sett_reg[12+i]};
         wire [3:0] eset = ctrl_reg[`AXM_CTL_EFILT_LSB +: 4];
         wire [2:0] ef;
         for (j = 0; j < 3; j = j + 1) begin : g_enc
            reg [3:0] ec_reg;
            reg ef_reg;
            // One process per filtered bit, so each bit has one driver
            always @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  ec_reg <= 4'h0;
                  ef_reg <= 1'b0;
               end else if (eraw[j] == ef_reg) begin
                  ec_reg <= 4'h0;
               end else if (ec_reg >= eset) begin
                  ef_reg <= eraw[j];
                  ec_reg <= 4'h0;
               end else begin
                  ec_reg <= ec_reg + 4'h1;
               end
            end
            assign ef[j] = ef_reg;
         end

         // Quadrature counter with index capture
         reg [1:0] qprev_reg;
         reg idx_d_reg;
         reg [31:0] pos_reg, icap_pos_reg;
         wire [1:0] qd = axm_quad({qprev_reg, ef[0], ef[1]});
         wire idx_edge = ef[2] & ~idx_d_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               qprev_reg <= 2'h0;
               idx_d_reg <= 1'b0;
               pos_reg <= 32'h0000_0000;
               icap_pos_reg <= 32'h0000_0000;
            end else begin
               qprev_reg <= {ef[0], ef[1]};
               idx_d_reg <= ef[2];
               if (sel && ofs == `AXM_OFS_POS) begin
                  pos_reg <= pwdata;
               // one edge per clock, 20 MHz headroom
               // runs whatever the axis is doing
               end else if (qd == 2'h1) begin
                  pos_reg <= pos_reg + 32'h0000_0001;
               end else if (qd == 2'h3) begin
                  pos_reg <= pos_reg - 32'h0000_0001;
               end
               if (arm_reg && idx_edge) begin
                  icap_pos_reg <= pos_reg;
               end
            end
         end

         // Step generator; half a pulse is period plus one clocks
         reg [15:0] rem_reg, div_reg;
         reg ph_reg, dir_reg;
         wire cmd_wr = sel && ofs == `AXM_OFS_STEP;
         // refusal lasts only while filtered active
         wire refuse = cmd_wr & (pwdata[31] ? act_en[1] : act_en[0]);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rem_reg <= 16'h0000;
               div_reg <= 16'h0000;
               ph_reg <= 1'b0;
               dir_reg <= 1'b0;
            end else if (halt) begin
               rem_reg <= 16'h0000;
               div_reg <= 16'h0000;
               ph_reg <= 1'b0;
            end else if (cmd_wr && !refuse) begin
               rem_reg <= pwdata[15:0];
               dir_reg <= pwdata[31];
               div_reg <= 16'h0000;
               ph_reg <= 1'b0;
            end else if (rem_reg != 16'h0000) begin
               if (div_reg >= cfg_reg[15:0]) begin
                  div_reg <= 16'h0000;
                  ph_reg <= ~ph_reg;
                  if (ph_reg) begin
                     rem_reg <= rem_reg - 16'h0001;
                  end
               end else begin
                  div_reg <= div_reg + 16'h0001;
               end
            end
         end

         // Software registers; sticky flags, set beats clear
         wire w1c = sel && ofs == `AXM_OFS_STAT;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_reg <= `AXM_CTRL_RST;
               cfg_reg <= {16'h0000, `AXM_PERIOD_RST};
               dlim_reg <= `AXM_DLIM_RST;
               dcmd_reg <= 32'h0000_0000;
               arm_reg <= 1'b0;
               act_d_reg <= 3'h0;
               killed_reg <= 1'b0;
               limstop_reg <= 1'b0;
               icap_reg <= 1'b0;
               refused_reg <= 1'b0;
            end else begin
               act_d_reg <= act_en;
               if (sel && ofs == `AXM_OFS_CTRL) begin
                  ctrl_reg <= pwdata[`AXM_CTL_WIDTH-1:0];
               end
               if (sel && ofs == `AXM_OFS_CFG) begin
                  cfg_reg <= pwdata;
               end
               if (sel && ofs == `AXM_OFS_DLIM) begin
                  dlim_reg <= pwdata;
               end
               if (sel && ofs == `AXM_OFS_DCMD) begin
                  dcmd_reg <= pwdata;
               end
               // Arm by software, disarmed by capture; arming wins
               if (sel && ofs == `AXM_OFS_CTRL && pwdata[`AXM_CTL_ARM]) begin
                  arm_reg <= 1'b1;
               end else if (idx_edge) begin
                  arm_reg <= 1'b0;
               end
               killed_reg <= (halt_all | kill_err[i]) |
                  (killed_reg & ~(w1c & pwdata[`AXM_ST_KILLED]));
               limstop_reg <= lim_trip | (limstop_reg & ~(w1c & pwdata[`AXM_ST_LIMSTOP]));
               icap_reg <= (arm_reg & idx_edge) | (icap_reg & ~(w1c & pwdata[`AXM_ST_ICAP]));
               refused_reg <= refuse | (refused_reg & ~(w1c & pwdata[`AXM_ST_REFUSED]));
            end
         end

         // clamp the command, then add offset, saturating
         wire signed [15:0] cmd = dcmd_reg[15:0];
         wire signed [15:0] ofsv = dcmd_reg[31:16];
         wire signed [15:0] plim = dlim_reg[31:16];
         wire signed [15:0] nlim = dlim_reg[15:0];
         wire signed [15:0] clmp = (cmd > plim) ? plim : ((cmd < nlim) ? nlim : cmd);
         wire signed [16:0] sum = {clmp[15], clmp} + {ofsv[15], ofsv};
         reg [15:0] dac_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dac_reg <= 16'h0000;
            end else if (sum[16] != sum[15]) begin
               dac_reg <= sum[16] ? 16'h8000 : 16'h7FFF;
            end else begin
               dac_reg <= sum[15:0];
            end
         end
         assign dac_value[16*i +: 16] = dac_reg;

         // Pin levels; oe_n low pulls the open-collector pin low
         wire mode = ctrl_reg[`AXM_CTL_MODE];
         // pulse mode splits pulses by direction
         wire s_lvl = mode ? (ph_reg & ~dir_reg) : ph_reg;
         wire d_lvl = mode ? (ph_reg & dir_reg) : dir_reg;
         // inhibit polarity, active-low unless set high
         // kill asserts inhibit when auto is enabled
         wire inh_act = ctrl_reg[`AXM_CTL_INH_SW] | (ctrl_reg[`AXM_CTL_AUTO_INH] & killed_reg);
         reg s_oe_reg, d_oe_reg, i_oe_reg;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s_oe_reg <= 1'b1;
               d_oe_reg <= 1'b1;
               i_oe_reg <= 1'b1;
            end else begin
               s_oe_reg <= s_lvl ^ ctrl_reg[`AXM_CTL_STEP_INV];
               d_oe_reg <= d_lvl ^ ctrl_reg[`AXM_CTL_DIR_INV];
               i_oe_reg <= ctrl_reg[`AXM_CTL_INH_HIGH] ? inh_act : ~inh_act;
            end
         end
         assign step_or_forward_pulse_oe_n[i] = s_oe_reg;
         assign direction_or_reverse_pulse_oe_n[i] = d_oe_reg;
         assign inhibit_oe_n[i] = i_oe_reg;

         // filtered and instant input states readable
         wire [31:0] stat = {20'h0_0000, refused_reg, icap_reg, limstop_reg, killed_reg,
            (rem_reg != 16'h0000), lvl, 1'b0, act};
         reg [31:0] rd;
         always @* begin
            case (ofs)
               `AXM_OFS_CTRL: rd = {8'h00, ctrl_reg[`AXM_CTL_WIDTH-1:17], arm_reg,
                  ctrl_reg[15:0]};
               `AXM_OFS_STEP: rd = {dir_reg, 15'h0000, rem_reg};
               `AXM_OFS_CFG: rd = cfg_reg;
               `AXM_OFS_STAT: rd = stat;
               `AXM_OFS_POS: rd = pos_reg;
               `AXM_OFS_ICAP: rd = icap_pos_reg;
               `AXM_OFS_DCMD: rd = dcmd_reg;
               default: rd = dlim_reg;
            endcase
         end
         assign rd_flat[32*i +: 32] = rd;
      end
   endgenerate
endmodule

// ### sim/axm_motion_chk.sv
`timescale 1ns/1ns
module axm_motion_chk #(
   parameter LIM_FILT_CYC = 20
) (
   input wire pclk, // Clock
   input wire presetn, // Reset, active low
   input wire psel, // Select
   input wire penable, // Access phase
   input wire pwrite, // Direction
   input wire [7:0] paddr, // Address
   input wire [31:0] pwdata, // Write data
   input wire [31:0] prdata, // Read data
   input wire pready, // Ready
   input wire pslverr, // Error
   input wire [3:0] kill_err, // Kill per axis
   input wire [3:0] step_or_forward_pulse_out, // Drive value
   input wire [3:0] step_or_forward_pulse_oe_n, // Step pin enable
   input wire [3:0] direction_or_reverse_pulse_out, // Drive value
   input wire [3:0] inhibit_out, // Drive value
   input wire [63:0] dac_value // Commands
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus phases
   wire setup = psel && !penable;
   wire wr = psel && penable && pwrite;
   // Halt-all write, then no new step pulse
   sequence s_halt;
      wr && paddr == 8'h00 && pwdata[0];
   endsequence
   sequence s_quiet;
      !$rose(step_or_forward_pulse_oe_n[0]) [*8];
   endsequence
   AST_READY: assert property (pready) else $error("ready low");
   AST_PINS_LOW: assert property ({step_or_forward_pulse_out, direction_or_reverse_pulse_out,
      inhibit_out} == 12'h000) else $error("open drain pin driven high");
   AST_UNMAPPED: assert property (setup && paddr >= 8'hA0 |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (setup && paddr >= 8'h20 && paddr < 8'hA0 |=> !pslverr)
      else $error("mapped access refused");
   AST_HOLD: assert property (!psel && !$past(psel) |-> $stable({prdata, pslverr}))
      else $error("read data moved while idle");
   AST_HALT_ALL: assert property (s_halt |=> ##1 s_quiet) else $error("step after halt");
   AST_KILL: assert property (kill_err[0] |-> ##2 s_quiet) else $error("step after kill");
   AST_DAC: assert property (!wr && !$past(wr) && !$past(wr, 2) |-> $stable(dac_value))
      else $error("command moved without write");
endmodule
bind axm_motion_io axm_motion_chk #(.LIM_FILT_CYC(LIM_FILT_CYC)) u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .kill_err,
   .step_or_forward_pulse_out, .step_or_forward_pulse_oe_n, .direction_or_reverse_pulse_out,
   .inhibit_out, .dac_value);

// ### sim/axm_far_model.sv
`timescale 1ns/1ns
module axm_far_model (
   input wire [3:0] step_oe_n, // Step pin enable
   input wire [3:0] dir_oe_n, // Direction pin enable
   input wire [3:0] inh_oe_n, // Inhibit pin enable
   input wire clr, // Clear counters
   output wire [3:0] step_pin, // Step pin level
   output wire [3:0] dir_pin, // Direction pin level
   output wire [3:0] inh_pin, // Inhibit pin level
   output logic [15:0] step_cnt, // Axis 0 step rises
   output logic [15:0] dir_cnt // Axis 0 direction rises
);
   // Pull-ups: a released pin reads high
   assign step_pin = step_oe_n;
   assign dir_pin = dir_oe_n;
   assign inh_pin = inh_oe_n;
   always @(posedge step_pin[0] or posedge clr) begin
      if (clr) step_cnt <= 16'h0000;
      else step_cnt <= step_cnt + 16'h0001;
   end
   always @(posedge dir_pin[0] or posedge clr) begin
      if (clr) dir_cnt <= 16'h0000;
      else dir_cnt <= dir_cnt + 16'h0001;
   end
endmodule

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
   logic pclk, presetn, psel, penable, pwrite, clr, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] fwd_limit_in, rev_limit_in, home_in, enc_a_in, enc_b_in, enc_index_in, kill_err;
   wire [3:0] s_oe, d_oe, i_oe, s_pin, d_pin, i_pin;
   logic [63:0] dac_value;
   logic [15:0] step_cnt, dir_cnt;
   logic [1:0] ph = 2'd0;
   int fails = 0, checked = 0, cycles = 0;
   // Short filter keeps limit tests brief
   axm_motion_io #(.LIM_FILT_CYC(20)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .fwd_limit_in, .rev_limit_in, .home_in, .enc_a_in,
      .enc_b_in, .enc_index_in, .kill_err, .step_or_forward_pulse_in(s_pin),
      .step_or_forward_pulse_out(), .step_or_forward_pulse_oe_n(s_oe),
      .direction_or_reverse_pulse_in(d_pin), .direction_or_reverse_pulse_out(),
      .direction_or_reverse_pulse_oe_n(d_oe), .inhibit_in(i_pin), .inhibit_out(),
      .inhibit_oe_n(i_oe), .dac_value);
   axm_far_model far (.step_oe_n(s_oe), .dir_oe_n(d_oe), .inh_oe_n(i_oe), .clr, .step_pin(s_pin),
      .dir_pin(d_pin), .inh_pin(i_pin), .step_cnt, .dir_cnt);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer; holds the request until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends once pready is high; the hang guard ends it if ready never comes
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Command a move on axis 0, poll until idle, count pulses
   task automatic move(input logic [31:0] cmd, input logic [15:0] es, input logic [15:0] ed);
      int n;
      n = 0;
      // Let a pin change from a control write land before clearing
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      wr(8'h24, cmd);
      do begin
         apb(1'b0, 8'h2C, 32'h0000_0000);
         n++;
      end while (rdat[7] !== 1'b0 && n < 200);
      chk({step_cnt, dir_cnt}, {es, ed});
   endtask
   task automatic t_regs();
      rd(8'h20, 32'h0000_0000);
      rd(8'h28, 32'h0000_0019);
      rd(8'h3C, 32'h7FFF_8000);
      rd(8'h2C, 32'h0000_0000);
      wr(8'hA4, 32'hFFFF_FFFF);
      rd(8'hA4, 32'h0000_0000);
      chk({31'h0, pslverr}, 32'h0000_0001);
      chk({28'h0, i_pin}, 32'h0000_000F);
      $display("test regs done");
   endtask
   task automatic t_step();
      wr(8'h28, 32'h0000_0001);
      move(32'h0000_0003, 16'h0003, 16'h0000);
      move(32'h8000_0002, 16'h0002, 16'h0001);
      chk({31'h0, d_pin[0]}, 32'h0000_0001);
      wr(8'h20, 32'h0000_0006);
      move(32'h0000_0002, 16'h0002, 16'h0001);
      chk({31'h0, d_pin[0]}, 32'h0000_0001);
      wr(8'h20, 32'h0000_0001);
      move(32'h8000_0002, 16'h0000, 16'h0002);
      move(32'h0000_0003, 16'h0003, 16'h0000);
      wr(8'h20, 32'h0000_0000);
      $display("test step done");
   endtask
   task automatic t_limit();
      wr(8'h20, 32'h0000_0100);
      wr(8'h24, 32'h0000_00C8);
      fwd_limit_in <= 4'h1;
      wait_n(8);
      rd(8'h2C, 32'h0000_0090);
      wait_n(40);
      rd(8'h24, 32'h0000_0000);
      rd(8'h2C, 32'h0000_0211);
      wr(8'h2C, 32'h0000_0F00);
      move(32'h0000_0002, 16'h0000, 16'h0000);
      rd(8'h2C, 32'h0000_0811);
      move(32'h8000_0001, 16'h0001, 16'h0001);
      fwd_limit_in <= 4'h0;
      wait_n(30);
      wr(8'h2C, 32'h0000_0F00);
      move(32'h0000_0001, 16'h0001, 16'h0000);
      wr(8'h20, 32'h0000_1000);
      wait_n(30);
      rd(8'h2C, 32'h0000_0011);
      move(32'h0000_0001, 16'h0001, 16'h0000);
      wr(8'h20, 32'h0000_0000);
      $display("test limit done");
   endtask
   // Quadrature on axis 0; phase A leads when stepping up
   task automatic quad(input int n, input logic [1:0] dir);
      repeat (n) begin
         ph = ph + dir;
         enc_a_in[0] <= ph[0] ^ ph[1];
         enc_b_in[0] <= ph[1];
         wait_n(4);
      end
      wait_n(10);
   endtask
   task automatic t_enc();
      quad(8, 2'd1);
      rd(8'h30, 32'h0000_0008);
      quad(12, 2'd3);
      rd(8'h30, 32'hFFFF_FFFC);
      wr(8'h20, 32'h0001_0000);
      enc_index_in <= 4'h1;
      wait_n(10);
      enc_index_in <= 4'h0;
      rd(8'h34, 32'hFFFF_FFFC);
      rd(8'h2C, 32'h0000_0400);
      wr(8'h2C, 32'h0000_0F00);
      // Filter setting 3 must reject a two-cycle index glitch
      wr(8'h20, 32'h0031_0000);
      enc_index_in <= 4'h1;
      wait_n(2);
      enc_index_in <= 4'h0;
      wait_n(12);
      rd(8'h2C, 32'h0000_0000);
      rd(8'h20, 32'h0031_0000);
      $display("test encoder done");
   endtask
   task automatic t_inhibit();
      wr(8'h20, 32'h0000_0020);
      kill_err <= 4'h1;
      @(posedge pclk);
      kill_err <= 4'h0;
      wait_n(3);
      chk({28'h0, i_pin}, 32'h0000_000E);
      rd(8'h2C, 32'h0000_0100);
      wr(8'h2C, 32'h0000_0F00);
      wait_n(2);
      chk({28'h0, i_pin}, 32'h0000_000F);
      wr(8'h20, 32'h0000_0010);
      wait_n(2);
      chk({28'h0, i_pin}, 32'h0000_000E);
      wr(8'h20, 32'h0000_0018);
      wait_n(2);
      chk({28'h0, i_pin}, 32'h0000_000F);
      wr(8'h20, 32'h0000_0008);
      wait_n(2);
      chk({28'h0, i_pin}, 32'h0000_000E);
      wr(8'h20, 32'h0000_0020);
      wr(8'h00, 32'h0000_0001);
      wait_n(2);
      chk({31'h0, i_pin[0]}, 32'h0000_0000);
      rd(8'h2C, 32'h0000_0100);
      $display("test inhibit done");
   endtask
   task automatic t_dac();
      wr(8'h38, 32'h0010_7FF0);
      wait_n(2);
      chk({16'h0, dac_value[15:0]}, 32'h0000_7FFF);
      wr(8'h3C, 32'h0100_FF00);
      wr(8'h38, 32'h0005_0200);
      wait_n(2);
      chk({16'h0, dac_value[15:0]}, 32'h0000_0105);
      wr(8'h38, 32'h0005_8000);
      wait_n(2);
      chk({16'h0, dac_value[15:0]}, 32'h0000_FF05);
      $display("test dac done");
   endtask
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, clr} = 5'b00000;
      {paddr, pwdata} = 40'h0;
      {fwd_limit_in, rev_limit_in, home_in, enc_a_in, enc_b_in, enc_index_in, kill_err} = 28'h0;
      wait_n(16);
      presetn <= 1'b1;
      t_regs();
      t_step();
      t_limit();
      t_enc();
      t_inhibit();
      t_dac();
      report_and_stop();
   end
endmodule
